// ==== bts_pkg.sv ====
`default_nettype none
package bts_pkg;

   // timing at 100 MHz (10 ns per cycle)
   localparam int unsigned CLK_PERIOD_NS      = 10;
   localparam int unsigned TSD_DEGLITCH_NS    = 100000;
   localparam int unsigned TSD_DEGLITCH_CYC   = TSD_DEGLITCH_NS / CLK_PERIOD_NS;
   localparam int unsigned TRIM_SETTLE_NS     = 1000;
   localparam int unsigned TRIM_SETTLE_CYC    = (TRIM_SETTLE_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;
   localparam int unsigned GPIO_DG_NS         = 100;
   localparam int unsigned GPIO_DG_CYC        = (GPIO_DG_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;
   localparam int unsigned LONG_DG_NS         = 500;
   localparam int unsigned LONG_DG_CYC        = (LONG_DG_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;
   // slow timer tick: 100 kHz from 100 MHz
   localparam int unsigned SLOW_TICK_HZ       = 100000;
   localparam int unsigned CLK_HZ             = 100000000;
   localparam int unsigned SLOW_DIV_CYC       = CLK_HZ / SLOW_TICK_HZ;

   localparam int unsigned CNT_W              = 14;
   localparam int unsigned NGPIO              = 9;

   // i2c address composition
   localparam logic [6:0]  I2C_BASE_ADDR      = 7'h20;
   localparam logic [1:0]  GPIO_MODE_PP       = 2'h0;
   localparam logic [1:0]  GPIO_MODE_WEAK     = 2'h1;
   localparam logic [1:0]  GPIO_MODE_OD       = 2'h2;

   // reset values
   localparam logic        STRAP_RST          = 1'b0;

   typedef enum logic [2:0] {
      BTS_ST_RESET  = 3'b000,
      BTS_ST_REGS   = 3'b001,
      BTS_ST_TRIM   = 3'b010,
      BTS_ST_SETTLE = 3'b011,
      BTS_ST_ADDR   = 3'b100,
      BTS_ST_DEADB  = 3'b101,
      BTS_ST_RUN    = 3'b110
   } bts_state_t;

endpackage
`default_nettype wire

// ==== bts_deglitch.sv ====
`timescale 1ns/1ps
`default_nettype none
module bts_deglitch
   import bts_pkg::*;
#(
   parameter int unsigned DG_CYC = 4
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic raw_i,
   output logic      filt_o
);
   logic [CNT_W-1:0] cnt_reg;
   logic             filt_reg;
   wire              differ = raw_i != filt_reg;
   wire              done   = cnt_reg >= CNT_W'(DG_CYC - 1);

   // output follows input only after it held a new level for DG_CYC cycles
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg  <= '0;
         filt_reg <= 1'b0;
      end else if (!differ) begin
         cnt_reg <= '0;
      end else if (done) begin
         cnt_reg  <= '0;
         filt_reg <= raw_i;
      end else begin
         cnt_reg <= cnt_reg + CNT_W'(1);
      end
   end
   assign filt_o = filt_reg;
endmodule
`default_nettype wire

// ==== bts_gpio_cell.sv ====
`timescale 1ns/1ps
`default_nettype none
module bts_gpio_cell
   import bts_pkg::*;
#(
   parameter int unsigned DG_CYC = 4
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [1:0] mode_i,
   input  wire logic       out_i,
   input  wire logic       oe_i,
   input  wire logic       analog_i,
   input  wire logic       pin_i,
   output logic            pin_o,
   output logic            pin_oe_o,
   output logic            weak_o,
   output logic            din_o,
   output logic            ana_route_o
);
   logic filt;

   // open drain only ever drives low; weak mode flags series resistance
   assign pin_o       = (mode_i == GPIO_MODE_OD) ? 1'b0 : out_i;
   assign pin_oe_o    = oe_i & ((mode_i != GPIO_MODE_OD) | ~out_i);
   assign weak_o      = mode_i == GPIO_MODE_WEAK;
   assign ana_route_o = analog_i & ~oe_i;

   bts_deglitch #(.DG_CYC(DG_CYC)) u_dg (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .raw_i  (pin_i & ~analog_i),
      .filt_o (filt)
   );
   // digital path blanked while the pin is an analog source
   assign din_o = filt & ~analog_i;
endmodule
`default_nettype wire

// ==== bts_supervisor.sv ====
// What this block does
// - internal reset held while regulator rail invalid, released once valid
// - after release enable core clocks, then pulse reset interrupt to core
// - boot code fetched from one-time memory after every power-on reset
// - boot order: registers, trim load, trim settle, then i2c addresses
// - i2c address built from otp bits, debug pins and address strap
// - dead battery when external 3.3 V invalid and vbus valid
// - strap pin sampled only in dead battery, selects vbus routing
// - core overtemp disables functions except supervisor and halts core
// - core resumes only below threshold minus hysteresis
// - path overtemp opens power switches quickly, own threshold/hysteresis
// - each thermal detector output deglitched before shutdown acts
// - every thermal shutdown event raises core interrupt
// - fast domain clocks core normally and the usb phy
// - independent slow domain drives timers and core in low power
// - gpio output push-pull, weak or open drain, pulls independent
// - gpio input is deglitched digital or analog to converter
// - gpio assignable to type-c, pd or application events
// - debug-control buffer like low-speed buffer with longer deglitch
// - port node buffer on for digital monitoring, off for analog
// - debug data pin comparator plus tristate driver, clock input pulled up
`timescale 1ns/1ps
`default_nettype none
module bts_supervisor
   import bts_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // supplies and straps
   input  wire logic             internal_regulator_rail_i,
   input  wire logic             external_supply_input_i,
   input  wire logic             vbus_valid_i,
   input  wire logic             bus_power_strap_pin_i,
   input  wire logic [1:0]       debug_control_pins_i,
   input  wire logic [1:0]       addr_strap_level_i,
   input  wire logic [3:0]       otp_addr_bits_i,
   // thermal comparators (hysteresis applied in analog)
   input  wire logic             core_overtemp_i,
   input  wire logic             path_overtemp_i,
   input  wire logic [1:0]       tsd_ack_i,
   // boot sequencing
   input  wire logic             trim_done_i,
   input  wire logic             low_power_i,
   // gpio control
   input  wire logic [2*NGPIO-1:0] gpio_mode_i,
   input  wire logic [NGPIO-1:0] gpio_out_i,
   input  wire logic [NGPIO-1:0] gpio_oe_i,
   input  wire logic [NGPIO-1:0] gpio_analog_i,
   input  wire logic [NGPIO-1:0] gpio_evt_sel_i,
   input  wire logic [NGPIO-1:0] gpio_pin_i,
   input  wire logic [NGPIO-1:0] event_i,
   input  wire logic [1:0]       dbgctl_pin_i,
   input  wire logic [1:0]       dbgctl_out_i,
   input  wire logic [1:0]       dbgctl_oe_i,
   input  wire logic [3:0]       dbgctl_mode_i,
   input  wire logic             port_monitor_i,
   input  wire logic             port_node_i,
   input  wire logic             swd_clk_pin_i,
   input  wire logic             swd_data_pin_i,
   input  wire logic             swd_data_out_i,
   input  wire logic             swd_data_oe_i,
   // outputs
   output logic                  core_rst_o,
   output logic                  core_clk_en_o,
   output logic                  reset_irq_o,
   output logic                  otp_fetch_o,
   output logic                  reg_init_o,
   output logic                  trim_load_o,
   output logic [6:0]            i2c_addr_o,
   output logic                  i2c_addr_valid_o,
   output logic                  dead_battery_o,
   output logic                  vbus_route_o,
   output logic                  boot_done_o,
   output logic                  core_halt_o,
   output logic                  func_disable_o,
   output logic                  switches_open_o,
   output logic                  thermal_irq_o,
   output logic [1:0]            tsd_status_o,
   output logic                  fast_clk_sel_o,
   output logic                  slow_tick_o,
   output logic [NGPIO-1:0]      gpio_pin_o,
   output logic [NGPIO-1:0]      gpio_pin_oe_o,
   output logic [NGPIO-1:0]      gpio_weak_o,
   output logic [NGPIO-1:0]      gpio_din_o,
   output logic [NGPIO-1:0]      gpio_ana_o,
   output logic [1:0]            dbgctl_pin_o,
   output logic [1:0]            dbgctl_pin_oe_o,
   output logic [1:0]            dbgctl_din_o,
   output logic                  port_node_din_o,
   output logic                  port_buf_en_o,
   output logic                  swd_clk_o,
   output logic                  swd_clk_pullup_o,
   output logic                  swd_data_din_o,
   output logic                  swd_data_pin_o,
   output logic                  swd_data_pin_oe_o
);

   ////////////////////////////////////////////////////////////////////////////
   // boot sequencer

   bts_state_t       state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic             irq_done_reg;
   logic             reset_irq_reg;
   logic [6:0]       addr_reg;
   logic             deadb_reg;
   logic             route_reg;
   wire              settle_done = cnt_reg >= CNT_W'(TRIM_SETTLE_CYC - 1);
   wire              por_hold    = ~internal_regulator_rail_i;

   // next state: any rail drop returns to reset
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         BTS_ST_RESET:  if (!por_hold) state_next = BTS_ST_REGS;
         BTS_ST_REGS:   if (irq_done_reg) state_next = BTS_ST_TRIM;
         BTS_ST_TRIM:   if (trim_done_i) state_next = BTS_ST_SETTLE;
         BTS_ST_SETTLE: if (settle_done) state_next = BTS_ST_ADDR;
         BTS_ST_ADDR:   state_next = BTS_ST_DEADB;
         BTS_ST_DEADB:  state_next = BTS_ST_RUN;
         BTS_ST_RUN:    state_next = BTS_ST_RUN;
         default:       state_next = BTS_ST_RESET;
      endcase
      if (por_hold) state_next = BTS_ST_RESET;
   end

   // settle counter only runs in its own state
   always_ff @(posedge clk_i) begin
      if (rst_i || state_reg != BTS_ST_SETTLE) cnt_reg <= '0;
      else cnt_reg <= cnt_reg + CNT_W'(1);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) state_reg <= BTS_ST_RESET;
      else state_reg <= state_next;
   end

   // one-cycle reset interrupt once clocks run after release
   always_ff @(posedge clk_i) begin
      if (rst_i || state_reg == BTS_ST_RESET) begin
         reset_irq_reg <= 1'b0;
         irq_done_reg  <= 1'b0;
      end else begin
         reset_irq_reg <= (state_reg == BTS_ST_REGS) && !irq_done_reg;
         irq_done_reg  <= 1'b1;
      end
   end

   // address: base plus strap, debug pins and otp mix
   wire [6:0] addr_calc = I2C_BASE_ADDR
                          ^ {otp_addr_bits_i, 3'h0}
                          ^ {3'h0, debug_control_pins_i, addr_strap_level_i};

   always_ff @(posedge clk_i) begin
      if (rst_i || state_reg == BTS_ST_RESET) begin
         addr_reg  <= 7'h00;
         deadb_reg <= 1'b0;
         route_reg <= STRAP_RST;
      end else begin
         if (state_reg == BTS_ST_ADDR) addr_reg <= addr_calc;
         if (state_reg == BTS_ST_DEADB) begin
            deadb_reg <= ~external_supply_input_i & vbus_valid_i;
            // strap is only looked at when booting from vbus alone
            if (~external_supply_input_i & vbus_valid_i)
               route_reg <= bus_power_strap_pin_i;
         end
      end
   end

   assign core_rst_o       = state_reg == BTS_ST_RESET;
   assign core_clk_en_o    = !core_rst_o && !core_halt_o;
   assign reset_irq_o      = reset_irq_reg;
   assign otp_fetch_o      = state_reg == BTS_ST_REGS;
   assign reg_init_o       = state_reg == BTS_ST_REGS;
   assign trim_load_o      = state_reg == BTS_ST_TRIM;
   assign i2c_addr_o       = addr_reg;
   assign i2c_addr_valid_o = state_reg == BTS_ST_DEADB || state_reg == BTS_ST_RUN;
   assign dead_battery_o   = deadb_reg;
   assign vbus_route_o     = route_reg;
   assign boot_done_o      = state_reg == BTS_ST_RUN;

   ////////////////////////////////////////////////////////////////////////////
   // thermal shutdown

   logic       core_hot;
   logic       path_hot;
   logic       core_hot_d_reg;
   logic       path_hot_d_reg;
   logic [1:0] tsd_flag_reg;

   // long filter hides comparator chatter near threshold
   bts_deglitch #(.DG_CYC(TSD_DEGLITCH_CYC)) u_dg_core (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .raw_i  (core_overtemp_i),
      .filt_o (core_hot)
   );
   bts_deglitch #(.DG_CYC(TSD_DEGLITCH_CYC)) u_dg_path (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .raw_i  (path_overtemp_i),
      .filt_o (path_hot)
   );

   wire core_rise = core_hot & ~core_hot_d_reg;
   wire path_rise = path_hot & ~path_hot_d_reg;

   // sticky flags: a new event wins over a simultaneous ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         core_hot_d_reg <= 1'b0;
         path_hot_d_reg <= 1'b0;
         tsd_flag_reg   <= 2'h0;
      end else begin
         core_hot_d_reg <= core_hot;
         path_hot_d_reg <= path_hot;
         tsd_flag_reg   <= (tsd_flag_reg & ~tsd_ack_i) | {path_rise, core_rise};
      end
   end

   // comparator release point carries the hysteresis, so we just follow it
   assign core_halt_o     = core_hot;
   assign func_disable_o  = core_hot;
   assign switches_open_o = path_hot;
   assign thermal_irq_o   = |tsd_flag_reg;
   assign tsd_status_o    = tsd_flag_reg;

   ////////////////////////////////////////////////////////////////////////////
   // clocks: fast domain select and slow timer tick

   logic [CNT_W-1:0] div_reg;
   wire              div_wrap = div_reg == CNT_W'(SLOW_DIV_CYC - 1);

   always_ff @(posedge clk_i) begin
      if (rst_i || div_wrap) div_reg <= '0;
      else div_reg <= div_reg + CNT_W'(1);
   end

   assign slow_tick_o    = div_wrap;
   assign fast_clk_sel_o = ~low_power_i & ~core_rst_o;

   ////////////////////////////////////////////////////////////////////////////
   // pin buffers

   logic [NGPIO-1:0] gpio_drv;
   // event routing: a pin either follows its hardware event or software
   assign gpio_drv = (gpio_evt_sel_i & event_i) | (~gpio_evt_sel_i & gpio_out_i);

   for (genvar g = 0; g < NGPIO; g++) begin : g_gpio
      bts_gpio_cell #(.DG_CYC(GPIO_DG_CYC)) u_cell (
         .clk_i       (clk_i),
         .rst_i       (rst_i),
         .mode_i      (gpio_mode_i[2*g +: 2]),
         .out_i       (gpio_drv[g]),
         .oe_i        (gpio_oe_i[g]),
         .analog_i    (gpio_analog_i[g]),
         .pin_i       (gpio_pin_i[g]),
         .pin_o       (gpio_pin_o[g]),
         .pin_oe_o    (gpio_pin_oe_o[g]),
         .weak_o      (gpio_weak_o[g]),
         .din_o       (gpio_din_o[g]),
         .ana_route_o (gpio_ana_o[g])
      );
   end

   for (genvar d = 0; d < 2; d++) begin : g_dbg
      // same cell with a longer filter, analog path tied off
      bts_gpio_cell #(.DG_CYC(LONG_DG_CYC)) u_cell (
         .clk_i       (clk_i),
         .rst_i       (rst_i),
         .mode_i      (dbgctl_mode_i[2*d +: 2]),
         .out_i       (dbgctl_out_i[d]),
         .oe_i        (dbgctl_oe_i[d]),
         .analog_i    (1'b0),
         .pin_i       (dbgctl_pin_i[d]),
         .pin_o       (dbgctl_pin_o[d]),
         .pin_oe_o    (dbgctl_pin_oe_o[d]),
         .weak_o      (),
         .din_o       (dbgctl_din_o[d]),
         .ana_route_o ()
      );
   end

   // port node buffer gated off so analog sees no digital load
   assign port_buf_en_o     = port_monitor_i;
   assign port_node_din_o   = port_monitor_i & port_node_i;
   // debug link: clock input only, pulled up; data with tristate driver
   assign swd_clk_o         = swd_clk_pin_i;
   assign swd_clk_pullup_o  = 1'b1;
   assign swd_data_din_o    = swd_data_pin_i;
   assign swd_data_pin_o    = swd_data_out_i;
   assign swd_data_pin_oe_o = swd_data_oe_i;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   sequence s_rail_up;
      core_rst_o ##1 !core_rst_o;
   endsequence

   por_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !internal_regulator_rail_i |=> core_rst_o)
      else $error("reset not held while rail invalid");

   reset_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_rail_up |=> reset_irq_o ##1 !reset_irq_o)
      else $error("reset irq not a single pulse after release");

   boot_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
      i2c_addr_valid_o && !$past(i2c_addr_valid_o) |-> $past(state_reg) == BTS_ST_ADDR)
      else $error("address valid before trim settle");

   dead_batt_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_reg == BTS_ST_DEADB && !por_hold |=>
         dead_battery_o == ($past(!external_supply_input_i && vbus_valid_i)))
      else $error("dead battery decision wrong");

   strap_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
      boot_done_o && $past(boot_done_o) |-> $stable(vbus_route_o))
      else $error("routing changed after boot");

   core_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
      core_hot |-> !core_clk_en_o && func_disable_o)
      else $error("core runs while overheated");

   tsd_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
      core_rise || path_rise |=> thermal_irq_o)
      else $error("thermal event raised no interrupt");

   flag_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tsd_flag_reg[0] && !tsd_ack_i[0] |=> tsd_flag_reg[0])
      else $error("thermal flag lost without ack");

   path_open_a: assert property (@(posedge clk_i) disable iff (rst_i)
      path_rise |-> switches_open_o)
      else $error("switches not opened on path overtemp");

   tick_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      slow_tick_o |=> !slow_tick_o [*8])
      else $error("slow tick too frequent");

endmodule
`default_nettype wire

// ==== bts_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bts_core_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       trim_load_i,
   input  wire logic [1:0] tsd_status_i,
   input  wire logic       ack_en_i,
   output logic            trim_done_o,
   output logic [1:0]      tsd_ack_o
);
   logic [3:0] trim_cnt_reg;
   // trims settle 8 cycles after the load strobe; done drops one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (rst_i || !trim_load_i) begin
         trim_cnt_reg <= 4'h0;
      end else if (trim_cnt_reg != 4'h8) begin
         trim_cnt_reg <= trim_cnt_reg + 4'h1;
      end
   end
   assign trim_done_o = (trim_cnt_reg == 4'h8);
   // core acks only on command, so a sticky flag can be seen meanwhile
   assign tsd_ack_o = ack_en_i ? tsd_status_i : 2'h0;
endmodule
`default_nettype wire

// ==== tb_bts_supervisor.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_bts_supervisor;
   import bts_pkg::*;
   logic clk_i, rst_i, internal_regulator_rail_i, external_supply_input_i, vbus_valid_i;
   logic bus_power_strap_pin_i, core_overtemp_i, path_overtemp_i, trim_done_i, low_power_i;
   logic [1:0] debug_control_pins_i, addr_strap_level_i, tsd_ack_i, dbgctl_pin_i;
   logic [1:0] dbgctl_out_i, dbgctl_oe_i, tsd_status_o, dbgctl_pin_o, dbgctl_pin_oe_o;
   logic [1:0] dbgctl_din_o;
   logic [3:0] otp_addr_bits_i, dbgctl_mode_i;
   logic [6:0] i2c_addr_o;
   logic [2*NGPIO-1:0] gpio_mode_i;
   logic [NGPIO-1:0] gpio_out_i, gpio_oe_i, gpio_analog_i, gpio_evt_sel_i, gpio_pin_i, event_i;
   logic [NGPIO-1:0] gpio_pin_o, gpio_pin_oe_o, gpio_weak_o, gpio_din_o, gpio_ana_o;
   logic port_monitor_i, port_node_i, swd_clk_pin_i, swd_data_pin_i, swd_data_out_i;
   logic swd_data_oe_i, core_rst_o, core_clk_en_o, reset_irq_o, otp_fetch_o, reg_init_o;
   logic trim_load_o, i2c_addr_valid_o, dead_battery_o, vbus_route_o, boot_done_o;
   logic core_halt_o, func_disable_o, switches_open_o, thermal_irq_o, fast_clk_sel_o;
   logic slow_tick_o, port_node_din_o, port_buf_en_o, swd_clk_o, swd_clk_pullup_o;
   logic swd_data_din_o, swd_data_pin_o, swd_data_pin_oe_o, ack_en;
   int err_total, num_checks, tick0;
   int cyc_n = 0, ticks = 0;

   bts_supervisor bts_supervisor_inst (.*);
   bts_core_model bts_core_model_inst (.clk_i(clk_i), .rst_i(rst_i),
      .trim_load_i(trim_load_o), .tsd_status_i(tsd_status_o), .ack_en_i(ack_en),
      .trim_done_o(trim_done_i), .tsd_ack_o(tsd_ack_i));

   ////////////////////////////////////////
   // clock, hang guard and slow tick count
   initial clk_i = 1'b0;
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (slow_tick_o === 1'b1) ticks <= ticks + 1;
      if (cyc_n == 90000) begin
         err_total++;
         test_done();
      end
   end

   ////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // one power-up: rail drop, then the whole boot walk with step timestamps
   task automatic boot(input logic e, input logic v, input logic s);
      int t, tg, tt, td, ta;
      logic irq, otp;
      logic [6:0] ea;
      {t, tg, tt, td, ta} = '0;
      {irq, otp} = 2'h0;
      internal_regulator_rail_i <= 1'b0;
      cyc(3);
      chk("core_rst", 1, core_rst_o);
      {external_supply_input_i, vbus_valid_i, bus_power_strap_pin_i} <= {e, v, s};
      internal_regulator_rail_i <= 1'b1;
      while (boot_done_o !== 1'b1 && t < 400) begin
         cyc(1);
         t++;
         if (reg_init_o === 1'b1 && tg == 0) tg = t;
         if (trim_load_o === 1'b1 && tt == 0) tt = t;
         if (trim_done_i === 1'b1 && td == 0) td = t;
         if (i2c_addr_valid_o === 1'b1 && ta == 0) ta = t;
         if (reset_irq_o === 1'b1 && core_rst_o === 1'b0) irq = 1'b1;
         if (otp_fetch_o === 1'b1) otp = 1'b1;
      end
      ea = I2C_BASE_ADDR ^ {otp_addr_bits_i, 3'h0};
      ea = ea ^ {3'h0, debug_control_pins_i, addr_strap_level_i};
      chk("boot_done", 1, boot_done_o);
      chk("rst_irq", 1, irq);
      chk("otp_fetch", 1, otp);
      chk("order", 1, tg > 0 && tg < tt && tt < td && ta - td >= TRIM_SETTLE_CYC);
      chk("clk_en", 1, core_clk_en_o);
      chk("addr", ea, i2c_addr_o);
      chk("deadb", !e && v, dead_battery_o);
      chk("route", (!e && v) ? s : STRAP_RST, vbus_route_o);
   endtask

   // glitch shorter than the filter, then a real event, recovery and ack
   task automatic therm(input int i);
      logic [1:0] b;
      b = 2'(1 << i);
      {path_overtemp_i, core_overtemp_i} <= b;
      cyc(TSD_DEGLITCH_CYC / 2);
      {path_overtemp_i, core_overtemp_i} <= 2'h0;
      cyc(3);
      chk("glitch", 0, {switches_open_o, core_halt_o});
      chk("glitch_flag", 0, tsd_status_o);
      {path_overtemp_i, core_overtemp_i} <= b;
      cyc(TSD_DEGLITCH_CYC + 20);
      chk("shutdown", b, {switches_open_o, core_halt_o});
      chk("func_dis", b[0], func_disable_o);
      chk("hot_clk", !b[0], core_clk_en_o);
      chk("flag", b, tsd_status_o);
      chk("tirq", 1, thermal_irq_o);
      {path_overtemp_i, core_overtemp_i} <= 2'h0;
      cyc(TSD_DEGLITCH_CYC + 20);
      chk("resume", 0, {switches_open_o, core_halt_o});
      chk("sticky", b, tsd_status_o);
      ack_en <= 1'b1;
      cyc(2);
      ack_en <= 1'b0;
      cyc(3);
      chk("cleared", 0, tsd_status_o);
      chk("tirq_off", 0, thermal_irq_o);
   endtask

   ////////////////////////////////////////
   initial begin
      {rst_i, internal_regulator_rail_i, external_supply_input_i, vbus_valid_i} = '0;
      {bus_power_strap_pin_i, core_overtemp_i, path_overtemp_i, low_power_i} = '0;
      {port_monitor_i, port_node_i, swd_clk_pin_i, swd_data_pin_i} = '0;
      {swd_data_out_i, swd_data_oe_i, ack_en, otp_addr_bits_i} = '0;
      {debug_control_pins_i, addr_strap_level_i, dbgctl_pin_i, dbgctl_out_i, dbgctl_oe_i} = '0;
      {gpio_mode_i, gpio_out_i, gpio_oe_i, gpio_analog_i, gpio_evt_sel_i} = '0;
      {gpio_pin_i, event_i} = '0;
      {err_total, num_checks, tick0} = '0;
      dbgctl_mode_i = {2{GPIO_MODE_OD}};
      rst_i = 1'b1;
      cyc(20);
      rst_i <= 1'b0;
      cyc(5);
      chk("rail_low", 1, core_rst_o);
      for (int i = 0; i < 4; i++) begin
         otp_addr_bits_i <= 4'(i * 5);
         debug_control_pins_i <= 2'(i);
         addr_strap_level_i <= 2'(3 - i);
         boot(i[0], i != 3, i < 2);
      end
      for (int i = 0; i < 2; i++) therm(i);
      tick0 = ticks;
      cyc(SLOW_DIV_CYC * 3);
      chk("ticks", 3, 9'(ticks - tick0));
      chk("fast_sel", 1, fast_clk_sel_o);
      low_power_i <= 1'b1;
      cyc(2);
      chk("slow_sel", 0, fast_clk_sel_o);
      {gpio_out_i, gpio_oe_i} <= '1;
      for (int m = 0; m < 3; m++) begin
         gpio_mode_i <= {NGPIO{2'(m)}};
         cyc(2);
         chk("gpio_oe", m == GPIO_MODE_OD ? 9'h0 : 9'h1ff, gpio_pin_oe_o);
         chk("gpio_weak", m == GPIO_MODE_WEAK ? 9'h1ff : 9'h0, gpio_weak_o);
      end
      gpio_out_i <= '0;
      cyc(2);
      chk("od_low_oe", 9'h1ff, gpio_pin_oe_o);
      chk("od_low", 0, gpio_pin_o);
      gpio_mode_i <= '0;
      {gpio_evt_sel_i, event_i} <= '1;
      cyc(2);
      chk("gpio_evt", 9'h1ff, gpio_pin_o);
      gpio_oe_i <= '0;
      gpio_analog_i <= '1;
      cyc(2);
      chk("gpio_ana", 9'h1ff, gpio_ana_o);
      gpio_analog_i <= '0;
      gpio_pin_i <= '1;
      cyc(3);
      gpio_pin_i <= '0;
      cyc(GPIO_DG_CYC + 5);
      chk("gpio_glitch", 0, gpio_din_o);
      gpio_pin_i <= '1;
      cyc(GPIO_DG_CYC + 5);
      chk("gpio_din", 9'h1ff, gpio_din_o);
      dbgctl_oe_i <= 2'h3;
      cyc(2);
      chk("dbg_oe", 3, dbgctl_pin_oe_o);
      chk("dbg_pin", 0, dbgctl_pin_o);
      dbgctl_out_i <= 2'h3;
      cyc(2);
      chk("dbg_rel", 0, dbgctl_pin_oe_o);
      dbgctl_mode_i <= 4'h0;
      cyc(2);
      chk("dbg_pp", 9'hf, {dbgctl_pin_o, dbgctl_pin_oe_o});
      dbgctl_pin_i <= 2'h3;
      cyc(GPIO_DG_CYC * 2);
      dbgctl_pin_i <= 2'h0;
      cyc(LONG_DG_CYC + 5);
      chk("dbg_glitch", 0, dbgctl_din_o);
      dbgctl_pin_i <= 2'h3;
      cyc(LONG_DG_CYC + 5);
      chk("dbg_din", 3, dbgctl_din_o);
      {port_monitor_i, port_node_i} <= 2'h3;
      cyc(2);
      chk("port_en", 1, port_buf_en_o);
      chk("port_din", 1, port_node_din_o);
      port_monitor_i <= 1'b0;
      cyc(2);
      chk("port_off", 0, port_buf_en_o);
      {swd_clk_pin_i, swd_data_out_i, swd_data_oe_i} <= 3'h7;
      cyc(2);
      chk("swd_clk", 1, swd_clk_o);
      chk("swd_pull", 1, swd_clk_pullup_o);
      chk("swd_drv", 3, {swd_data_pin_o, swd_data_pin_oe_o});
      chk("swd_in0", 0, swd_data_din_o);
      {swd_data_oe_i, swd_data_pin_i} <= 2'h1;
      cyc(2);
      chk("swd_tri", 0, swd_data_pin_oe_o);
      chk("swd_in1", 1, swd_data_din_o);
      internal_regulator_rail_i <= 1'b0;
      cyc(2);
      chk("rail_drop", 1, core_rst_o);
      chk("addr_clr", 0, i2c_addr_valid_o);
      test_done();
   end
endmodule
`default_nettype wire
